/* File: design/cfs_pkg.sv */
/*
 Package for the converter status register block: register addresses,
 field positions, reset values, carrier structs.
 Assumes a register-read port from the serial interface logic on i_mclk.
*/
// Overview of operation
// [RQ1] Top three bits show active driver pairs
// [RQ2] Driver bits zero when idle, done, stopped, reset
// [RQ3] Running function shown one-hot in low nine
// [RQ4] Function code 0010 reads as bit 2
// [RQ5] Function bits clear on done, stop, reset
// [RQ6] Scan mode keeps bit 0/1 on no-touch end
// [RQ7] Held scan bit restarts scan on next touch
// [RQ8] Function status read-only at address F, resets 0
// [RQ9] Status register at address 8, resets 0004
// [RQ10] Data-available bits set on store, clear after reads
// [RQ11] Reset flag reads 0 after reset, then 1
// [RQ12] Power-down status follows bias select when synchronized
// [RQ13] Reserved bits zero; reads keep function bits
package cfs_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0]  CFS_ADDR_STATUS   = 4'h8;
	localparam logic [3:0]  CFS_ADDR_FUNC     = 4'hf;
	localparam logic [15:0] CFS_STATUS_RESET  = 16'h0004;
	localparam logic [15:0] CFS_FUNC_RESET    = 16'h0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFS_DRV_LSB   = 13;
	localparam int CFS_FN_BITS   = 9;
	localparam int CFS_DAV_LSB   = 11;
	localparam int CFS_DAV_BITS  = 5;
	localparam int CFS_RSTF_POS  = 7;
	localparam int CFS_POWERDOWN_STATUS_BIT_POS  = 2;
	localparam logic [3:0] CFS_FN_SCAN_MAX = 4'h1;

	// Driver pairs: x both, y both, y+ with x-
	typedef struct packed {
		logic yp_xn;
		logic y_both;
		logic x_both;
	} cfs_drv_t;

	// Converter events from sequencing logic
	typedef struct packed {
		logic       start;
		logic [3:0] code;
		logic       done;
		logic       no_touch_end;
		logic       stop;
	} cfs_fn_evt_t;

endpackage

/* File: design/cfs_dav_flags.sv */
/*
 Data-available flag bank: one sticky bit per data type.
 Assumes store and all-read pulses come from logic on i_mclk.
*/
`timescale 1ns/1ps
module cfs_dav_flags #(
	parameter int N = 5
) (
	input  wire logic         i_mclk,
	input  wire logic         i_reset,
	input  wire logic         i_sw_reset,
	input  wire logic [N-1:0] i_store,
	input  wire logic [N-1:0] i_read_done,
	output logic      [N-1:0] o_dav
);
	import cfs_pkg::*;

	if (N < 1)
	begin : g_bad_n
		$error("cfs_dav_flags needs N >= 1");
	end

	logic [N-1:0] dav_ff;
	logic [N-1:0] nxt_dav;

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_flag
			// Store wins over read clear so no update is lost; software reset wins over store
			always_comb
			begin
				if (i_sw_reset)
					nxt_dav[g] = 1'b0;
				else if (i_store[g])
					nxt_dav[g] = 1'b1; // [RQ10]
				else if (i_read_done[g])
					nxt_dav[g] = 1'b0; // [RQ10]
				else
					nxt_dav[g] = dav_ff[g];
			end
		end
	endgenerate

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			dav_ff <= '0;
		else
			dav_ff <= nxt_dav;
	end

	assign o_dav = dav_ff;
endmodule // cfs_dav_flags

/* File: design/cfs_status_regs.sv */
/*
 Converter-function status and device status registers, read-only.
 Assumes the serial interface presents a 4-bit register address with a
 one-cycle read strobe, and sequencing logic reports events on i_mclk.
 Pen touch arrives from the analog side and is synchronized here.
 Read data is registered and held until the next read; ack is one cycle.
 Reads never disturb the function bits, only the reset flag.
*/
`timescale 1ns/1ps
module cfs_status_regs (
	input  wire logic                 i_mclk,
	input  wire logic                 i_reset,
	input  wire logic                 i_sw_reset,
	input  wire cfs_pkg::cfs_fn_evt_t i_fn_evt,
	input  wire cfs_pkg::cfs_drv_t    i_drv,
	input  wire logic                 i_scan_mode_select,
	input  wire logic                 i_bias_powerdown_select,
	input  wire logic                 i_pen_touch_irq_n,
	input  wire logic [4:0]           i_dav_store,
	input  wire logic [4:0]           i_dav_read_done,
	input  wire logic                 i_rd_stb,
	input  wire logic [3:0]           i_rd_addr,
	output logic      [15:0]          o_rd_data,
	output logic                      o_rd_ack,
	output logic                      o_scan_restart,
	output logic      [3:0]           o_scan_code
);
	import cfs_pkg::*;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Ports are sized for five data types and nine functions
	if (CFS_DAV_BITS != 5 || CFS_FN_BITS + 4 != CFS_DRV_LSB)
	begin : g_bad_layout
		$error("cfs_status_regs: field layout does not fit the ports");
	end

	// ----------------------------------------
	// Pen touch synchronizer
	// ----------------------------------------
	logic [2:0] pen_sync_ff;
	logic       pen_ff;
	logic       nxt_pen;
	logic       pen_edge;

	always_comb
	begin
		// Change accepted once stages two and three agree
		nxt_pen = (pen_sync_ff[1] == pen_sync_ff[2]) ? ~pen_sync_ff[2] : pen_ff;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			pen_sync_ff <= 3'h7;
			pen_ff      <= 1'b0;
		end
		else
		begin
			pen_sync_ff <= {pen_sync_ff[1:0], i_pen_touch_irq_n};
			pen_ff      <= nxt_pen;
		end
	end

	assign pen_edge = nxt_pen & ~pen_ff;

	// ----------------------------------------
	// Converter function status
	// ----------------------------------------
	logic [CFS_FN_BITS-1:0] fn_ff;
	logic [CFS_FN_BITS-1:0] nxt_fn;
	logic [2:0]             drv_ff;
	logic [2:0]             nxt_drv;
	logic                   scan_held;

	assign scan_held = i_scan_mode_select & |fn_ff[1:0];

	// ----------------------------------------
	// Converter event decode
	// ----------------------------------------
	logic fn_load;
	logic fn_end;
	logic fn_keep;
	logic fn_kill;

	assign fn_load = i_fn_evt.start && i_fn_evt.code < 4'(CFS_FN_BITS);
	assign fn_end  = i_fn_evt.done || i_fn_evt.no_touch_end;
	// Only a no-touch end in scan mode keeps the bit armed
	assign fn_keep = i_fn_evt.no_touch_end && i_scan_mode_select && i_fn_evt.code <= CFS_FN_SCAN_MAX;
	assign fn_kill = i_fn_evt.stop || i_sw_reset;

	always_comb
	begin
		nxt_fn  = fn_ff;
		nxt_drv = {i_drv.yp_xn, i_drv.y_both, i_drv.x_both}; // [RQ1]
		if (fn_load)
			nxt_fn = CFS_FN_BITS'(1) << i_fn_evt.code; // [RQ3] [RQ4]
		if (fn_keep)
			nxt_fn = fn_ff; // [RQ6]
		else if (fn_end)
			nxt_fn = '0; // [RQ5]
		if (fn_end || fn_kill)
			nxt_drv = 3'h0; // [RQ2]
		if (fn_kill)
			nxt_fn = '0; // [RQ5]
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			fn_ff  <= CFS_FUNC_RESET[CFS_FN_BITS-1:0]; // [RQ8]
			drv_ff <= 3'h0; // [RQ2]
		end
		else
		begin
			fn_ff  <= nxt_fn;
			drv_ff <= nxt_drv;
		end
	end

	// Held bit restarts the scan without a host command
	assign o_scan_restart = scan_held & pen_edge; // [RQ7]
	assign o_scan_code    = fn_ff[1] ? 4'h1 : 4'h0;

	// ----------------------------------------
	// Device status
	// ----------------------------------------
	logic [4:0] dav;
	logic       rstf_ff;
	logic       nxt_rstf;
	logic       powerdown_status_bit_ff;
	logic       nxt_powerdown_status_bit;

	cfs_dav_flags #(
		.N (CFS_DAV_BITS)
	) u_dav (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.i_sw_reset  (i_sw_reset),
		.i_store     (i_dav_store),
		.i_read_done (i_dav_read_done),
		.o_dav       (dav)
	);

	always_comb
	begin
		nxt_rstf = rstf_ff;
		nxt_powerdown_status_bit = powerdown_status_bit_ff;
		if (i_sw_reset)
			nxt_rstf = 1'b0; // [RQ11]
		else if (i_rd_stb && i_rd_addr == CFS_ADDR_STATUS)
			nxt_rstf = 1'b1; // [RQ11]
		// Sampled only on touch or start: bias select is slow-moving
		if (i_sw_reset)
			nxt_powerdown_status_bit = CFS_STATUS_RESET[CFS_POWERDOWN_STATUS_BIT_POS];
		else if (pen_edge || i_fn_evt.start)
			nxt_powerdown_status_bit = i_bias_powerdown_select; // [RQ12]
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			rstf_ff <= CFS_STATUS_RESET[CFS_RSTF_POS]; // [RQ11]
			powerdown_status_bit_ff <= CFS_STATUS_RESET[CFS_POWERDOWN_STATUS_BIT_POS]; // [RQ9]
		end
		else
		begin
			rstf_ff <= nxt_rstf;
			powerdown_status_bit_ff <= nxt_powerdown_status_bit;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [15:0] status_word;
	logic [15:0] func_word;
	logic [15:0] rd_data_ff;
	logic [15:0] nxt_rd_data;
	logic        ack_ff;
	logic        nxt_ack;

	always_comb
	begin
		status_word = 16'h0000; // [RQ13]
		status_word[CFS_DAV_LSB +: CFS_DAV_BITS] = dav; // [RQ10]
		status_word[CFS_RSTF_POS] = rstf_ff; // [RQ11]
		status_word[CFS_POWERDOWN_STATUS_BIT_POS] = powerdown_status_bit_ff; // [RQ9] [RQ12]
		func_word = 16'h0000; // [RQ13]
		func_word[CFS_DRV_LSB +: 3] = drv_ff; // [RQ1]
		func_word[CFS_FN_BITS-1:0] = fn_ff; // [RQ3]
		nxt_rd_data = rd_data_ff;
		nxt_ack     = i_rd_stb;
		if (i_rd_stb)
		begin
			unique case (i_rd_addr)
				CFS_ADDR_STATUS: nxt_rd_data = status_word; // [RQ9]
				CFS_ADDR_FUNC:   nxt_rd_data = func_word; // [RQ8]
				default:         nxt_rd_data = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			rd_data_ff <= 16'h0000;
			ack_ff     <= 1'b0;
		end
		else
		begin
			rd_data_ff <= nxt_rd_data;
			ack_ff     <= nxt_ack;
		end
	end

	assign o_rd_data = rd_data_ff;
	assign o_rd_ack  = ack_ff;
endmodule // cfs_status_regs

/* File: sim/cfs_status_regs_sva.sv */
/* Checker for the status register read port.
 Assumes binding onto cfs_status_regs, one clock. */
`timescale 1ns/1ps
module cfs_status_regs_sva
	import cfs_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_reset,
	input wire logic        i_sw_reset,
	input wire logic        i_scan_mode_select,
	input wire logic        i_pen_touch_irq_n,
	input wire logic        i_rd_stb,
	input wire logic [3:0]  i_rd_addr,
	input wire logic [15:0] o_rd_data,
	input wire logic        o_rd_ack,
	input wire logic        o_scan_restart,
	input wire logic [3:0]  o_scan_code
);
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	a_ack_after_rd: assert property (i_rd_stb |=> o_rd_ack) else $error("no ack");
	a_ack_no_rd: assert property (!i_rd_stb |=> !o_rd_ack) else $error("stray ack");
	a_func_resv: assert property (o_rd_ack && $past(i_rd_addr) == CFS_ADDR_FUNC |-> o_rd_data[12:9] == 4'h0)
		else $error("func reserved");
	a_func_onehot: assert property (o_rd_ack && $past(i_rd_addr) == CFS_ADDR_FUNC |-> $onehot0(o_rd_data[8:0]))
		else $error("func not one-hot");
	a_stat_resv: assert property (o_rd_ack && $past(i_rd_addr) == CFS_ADDR_STATUS
		|-> o_rd_data[10:8] == 3'h0 && o_rd_data[6:3] == 4'h0 && o_rd_data[1:0] == 2'h0) else $error("stat reserved");
	a_unmapped_zero: assert property (o_rd_ack && !($past(i_rd_addr) inside {4'h8, 4'hf}) |-> o_rd_data == 16'h0000)
		else $error("unmapped");
	a_restart_code: assert property (o_scan_restart |-> i_scan_mode_select && o_scan_code <= CFS_FN_SCAN_MAX)
		else $error("scan code");
	a_restart_filter: assert property (o_scan_restart
		|-> !$past(i_pen_touch_irq_n, 2) && !$past(i_pen_touch_irq_n, 3)) else $error("restart without touch");
	a_restart_pulse: assert property (o_scan_restart |=> !o_scan_restart) else $error("restart held");
	a_reset_flag: assert property (i_sw_reset ##1 (i_rd_stb && i_rd_addr == 4'h8) |=> !o_rd_data[7])
		else $error("reset flag");
	// Main scenarios reached
	cover property (o_scan_restart);
	cover property (o_scan_restart && o_scan_code == 4'h0);
	cover property (o_rd_ack && o_rd_data[15:11] != 5'h00);
	cover property (o_rd_ack && o_rd_data[8:0] != 9'h000);
endmodule // cfs_status_regs_sva
bind cfs_status_regs cfs_status_regs_sva u_sva (.i_mclk(i_mclk), .i_reset(i_reset), .i_sw_reset(i_sw_reset),
	.i_scan_mode_select(i_scan_mode_select), .i_pen_touch_irq_n(i_pen_touch_irq_n),
	.i_rd_stb(i_rd_stb), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .o_rd_ack(o_rd_ack),
	.o_scan_restart(o_scan_restart), .o_scan_code(o_scan_code));

/* File: sim/cfs_host.sv */
/* Host read model standing in for the serial master.
 Assumes the one-cycle ack of the read port. */
`timescale 1ns/1ps
module cfs_host (
	input  wire logic        i_mclk,
	input  wire logic        i_ack,
	input  wire logic [15:0] i_data,
	output logic             o_stb,
	output logic      [3:0]  o_addr
);
	initial
	begin
		o_stb = 1'b0;
		o_addr = 4'h0;
	end
	task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
		@(negedge i_mclk);
		o_stb = 1'b1;
		o_addr = a;
		@(negedge i_mclk);
		o_stb = 1'b0;
		o_addr = ~a; // Idle address never repeats the last one
		ok = i_ack;
		d = i_data;
	endtask
endmodule // cfs_host

/* File: sim/tb.sv */
/* Self-checking bench for cfs_status_regs.
 Assumes the host model issues all reads. */
`timescale 1ns/1ps
module tb;
	import cfs_pkg::*;
	logic        clk, rst, swr, scan, bias, pen, stb, ack, rs;
	logic [3:0]  ad, sc;
	logic [4:0]  st, rdn, dv;
	logic [15:0] d;
	cfs_fn_evt_t ev;
	cfs_drv_t    drv;
	int          bad_count, n_checks, seed, i, k;
	cfs_status_regs dut (.i_mclk(clk), .i_reset(rst), .i_sw_reset(swr), .i_fn_evt(ev), .i_drv(drv),
		.i_scan_mode_select(scan), .i_bias_powerdown_select(bias), .i_pen_touch_irq_n(pen), .i_dav_store(st),
		.i_dav_read_done(rdn), .i_rd_stb(stb), .i_rd_addr(ad), .o_rd_data(d), .o_rd_ack(ack),
		.o_scan_restart(rs), .o_scan_code(sc));
	cfs_host host (.i_mclk(clk), .i_ack(ack), .i_data(d), .o_stb(stb), .o_addr(ad));
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task chk(string n, logic [16:0] e, logic [16:0] g);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task rc(logic [3:0] a, logic [15:0] e, string n);
		logic [15:0] q;
		logic        ok;
		host.rd(a, q, ok);
		chk(n, {1'b1, e}, {ok, q});
	endtask
	function logic [15:0] xs(logic [4:0] v, logic f, logic p);
		return {v, 3'h0, f, 4'h0, p, 2'h0};
	endfunction
	task ev1(logic [3:0] c, logic s, logic dn, logic nt, logic sp);
		@(negedge clk);
		ev = {s, c, dn, nt, sp};
		@(negedge clk);
		ev = '0;
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		seed = 38694;
		{swr, scan, st, rdn, ev, drv} = '0;
		{rst, bias, pen} = 3'h7;
		repeat (8) @(negedge clk);
		rst = 0;
		begin : run
			rc(4'h8, CFS_STATUS_RESET, "status");
			rc(4'h8, xs(0, 1, 1), "status");
			rc(4'hf, CFS_FUNC_RESET, "func");
			rc(4'h3, 16'h0000, "unmapped");
			$display("test reset done");
			for (i = 0; i < 16; i++)
			begin
				drv = 3'($random(seed));
				ev1(i[3:0], 1, 0, 0, 0);
				rc(4'hf, {drv, 4'h0, 9'h1 << i}, "func");
				drv = '0;
				ev1(i[3:0], 0, !i[0], 0, i[0]);
				rc(4'hf, 16'h0000, "func clear");
			end
			$display("test codes done");
			scan = 1;
			for (k = 0; k < 2; k++)
			begin
				ev1(k[3:0], 1, 0, 0, 0);
				ev1(k[3:0], 0, 1, 1, 0);
				rc(4'hf, 16'h0001 << k, "scan hold");
				pen = 0;
				for (i = 0; i < 20 && rs !== 1'b1; i++)
				begin
					@(posedge clk);
					#1;
				end
				if (i >= 20)
				begin
					bad_count++;
					disable run;
				end
				chk("restart", {1'b1, k[3:0]}, {rs, sc});
				@(negedge clk);
				{pen, swr} = 2'h3;
				fork
					rc(4'h8, xs(0, 0, 1), "status");
					@(negedge clk) swr = 0;
				join
				rc(4'hf, 16'h0000, "func");
			end
			scan = 0;
			ev1(4'h1, 1, 0, 0, 0);
			ev1(4'h1, 0, 1, 1, 0);
			rc(4'hf, 16'h0000, "no scan");
			$display("test scan done");
			dv = 5'($random(seed));
			st = dv;
			@(negedge clk);
			st = '0;
			rc(4'h8, xs(dv, 1, 1), "dav");
			{bias, rdn} = 6'h1f;
			@(negedge clk);
			rdn = '0;
			ev1(4'h2, 1, 0, 0, 0); // Start resyncs power-down status
			rc(4'h8, xs(0, 1, 0), "powerdown_status_bit");
			$display("test status done");
			rst = 1;
			repeat (2) @(negedge clk);
			rst = 0;
			rc(4'h8, CFS_STATUS_RESET, "hw status");
			rc(4'hf, CFS_FUNC_RESET, "hw func");
			$display("test hw reset done");
		end
		final_report();
	end
endmodule // tb
